// *** instr_decode_params.svh ***
// constants for the instruction field decoder and cycle timing
`ifndef INSTR_DECODE_PARAMS_SVH
`define INSTR_DECODE_PARAMS_SVH

// ============================================================
// instruction word layout
`define WORD_W 14
`define GRP_HI_POS 13
`define GRP_LO_POS 12
`define LONG_SEL_VAL 1'b0
`define REG_IDX_W 7
`define REG_IDX_HI 6
`define REG_IDX_LO 0
`define TARGET_POS 7
`define FLAG_POS_W 3
`define FLAG_POS_HI 9
`define FLAG_POS_LO 7
`define LIT_W 11
`define LIT_SHORT_W 8
`define LIT_SHORT_HI 7
`define LIT_LONG_HI 10
`define LIT_LO 0

// ============================================================
// timing
`define OSC_PERIOD_NS 10
`define OSC_PER_CYCLE 4
`define PHASE_W 2
`define PHASE_LAST 2'h3
`define PHASE_PRE_LAST 2'h2
`define QCLK_RISE_PRE 2'h1
`define QCLK_FALL_PRE 2'h3
`define PC_W_DEFAULT 11
`define PC_W_MAX 16

`endif

// *** instr_decode_pkg.sv ***
// shared types of the instruction field decoder
package instr_decode_pkg;

  // ============================================================
  // operation groups
  typedef enum logic [1:0] {
    GRP_BYTE,
    GRP_BIT,
    GRP_LITERAL
  } op_group_t;

  // ============================================================
  // execution slot of an instruction cycle
  typedef enum logic {
    ST_EXEC,
    ST_FLUSH
  } slot_t;

endpackage

// *** decode_fields_if.sv ***
// interface carrying an instruction word and its decoded fields
`timescale 1ns/100ps
`default_nettype none
`include "instr_decode_params.svh"

interface decode_fields_if;
  logic [`WORD_W-1:0] word;
  instr_decode_pkg::op_group_t group;
  logic [`REG_IDX_W-1:0] reg_index;
  logic result_target;
  logic [`FLAG_POS_W-1:0] flag_position;
  logic [`LIT_W-1:0] literal_value;
  logic long_literal;

  modport decoder (
    input word,
    output group,
    output reg_index,
    output result_target,
    output flag_position,
    output literal_value,
    output long_literal
  );

  modport user (
    output word,
    input group,
    input reg_index,
    input result_target,
    input flag_position,
    input literal_value,
    input long_literal
  );
endinterface

`default_nettype wire

// *** field_decoder.sv ***
// combinational split of an instruction word into group and operands
`timescale 1ns/100ps
`default_nettype none
`include "instr_decode_params.svh"

module field_decoder (
  decode_fields_if.decoder dec // word in, fields out
);
  // ============================================================
  // group select
  wire is_lit = dec.word[`GRP_HI_POS];
  wire is_bit = !is_lit && dec.word[`GRP_LO_POS];
  wire is_byte = !is_lit && !dec.word[`GRP_LO_POS];
  wire is_long = is_lit && (dec.word[`GRP_LO_POS] == `LONG_SEL_VAL);

  assign dec.group = is_lit ? instr_decode_pkg::GRP_LITERAL :
                     is_bit ? instr_decode_pkg::GRP_BIT :
                     instr_decode_pkg::GRP_BYTE;

  // ============================================================
  // operands; unused bits are never looked at
  assign dec.reg_index = is_lit ? {`REG_IDX_W{1'b0}} :
                         dec.word[`REG_IDX_HI:`REG_IDX_LO];
  assign dec.result_target = is_byte && dec.word[`TARGET_POS];
  assign dec.flag_position = is_bit ?
                             dec.word[`FLAG_POS_HI:`FLAG_POS_LO] :
                             {`FLAG_POS_W{1'b0}};
  assign dec.long_literal = is_long;
  assign dec.literal_value = !is_lit ? {`LIT_W{1'b0}} :
      is_long ? dec.word[`LIT_LONG_HI:`LIT_LO] :
      {{(`LIT_W-`LIT_SHORT_W){1'b0}}, dec.word[`LIT_SHORT_HI:`LIT_LO]};
endmodule

`default_nettype wire

// *** cycle_phase_counter.sv ***
// divider that splits each instruction cycle into oscillator periods
`timescale 1ns/100ps
`default_nettype none
`include "instr_decode_params.svh"

module cycle_phase_counter (
  input wire logic clk, // oscillator clock
  input wire logic srst, // synchronous reset
  output logic [`PHASE_W-1:0] phase, // current period of the cycle
  output logic cyc_last // last period of the cycle
);
  logic [`PHASE_W-1:0] phase_r;
  logic [`PHASE_W-1:0] phase_nxt;

  // ============================================================
  // wraps after the last period
  assign phase_nxt = (phase_r == `PHASE_LAST) ? {`PHASE_W{1'b0}} :
                     phase_r + {{(`PHASE_W-1){1'b0}}, 1'b1};
  assign phase = phase_r;
  assign cyc_last = (phase_r == `PHASE_LAST);

  always_ff @(posedge clk) begin
    if (srst) begin
      phase_r <= {`PHASE_W{1'b0}};
    end else begin
      phase_r <= phase_nxt;
    end
  end
endmodule

`default_nettype wire

// *** instruction_field_decode_timing.sv ***
// instruction fetch, field decode and cycle sequencing of the core
// Contract
// - every instruction is one 14-bit word: opcode part plus operand fields
// - each word falls into exactly one of byte, bit, literal groups
// - byte ops: target 0 writes accumulator, target 1 writes the register
// - register index is a 7-bit field addressing 0x00 to 0x7f
// - bit ops: flag position picks one bit of the indexed register
// - literal ops take an 8-bit or 11-bit constant per instruction
// - don't-care bits never change behaviour, whether 0 or 1
// - one cycle per instruction; taken test or pc change adds a no-op
// - an instruction cycle is exactly four oscillator periods
// - rc oscillator mode drives quarter-rate clock, period four periods
`timescale 1ns/100ps
`default_nettype none
`include "instr_decode_params.svh"

module instruction_field_decode_timing #(
  parameter int PC_W = `PC_W_DEFAULT
) (
  input wire logic clk, // oscillator clock, 100 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic resistor_capacitor_oscillator, // rc mode strap pin
  input wire logic [`WORD_W-1:0] instr_word, // program memory word
  input wire logic pc_load, // executing op changes the pc
  input wire logic [PC_W-1:0] pc_target, // new pc with pc_load
  input wire logic skip_taken, // executing op's test is true
  output logic fetch_req, // one-period fetch strobe
  output logic [PC_W-1:0] fetch_addr, // address being fetched
  output instr_decode_pkg::op_group_t op_group, // group of op
  output logic [`REG_IDX_W-1:0] reg_index, // register file index
  output logic result_target, // 0 accumulator, 1 register
  output logic [`FLAG_POS_W-1:0] flag_position, // bit within register
  output logic [`LIT_W-1:0] literal_value, // literal operand
  output logic long_literal, // literal is 11 bits wide
  output logic exec_valid, // a real op executes this cycle
  output logic acc_write, // accumulator write strobe
  output logic file_write, // register file write strobe
  output logic status_write, // status flag write strobe
  output logic [`PHASE_W-1:0] osc_phase, // period within the cycle
  output logic quarter_rate_clock_out // quarter-rate clock in rc mode
);
  // ============================================================
  // parameter check
  if (PC_W < 1 || PC_W > `PC_W_MAX) begin : g_bad_pc_w
    $error("PC_W out of range");
  end

  // ============================================================
  // cycle timing
  logic [`PHASE_W-1:0] phase_w;
  logic cyc_last;
  wire pre_last = (phase_w == `PHASE_PRE_LAST);

  cycle_phase_counter u_phase (
    .clk(clk),
    .srst(srst),
    .phase(phase_w),
    .cyc_last(cyc_last)
  );

  logic [`PHASE_W-1:0] osc_phase_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      osc_phase_r <= {`PHASE_W{1'b0}};
    end else begin
      osc_phase_r <= (phase_w == `PHASE_LAST) ? {`PHASE_W{1'b0}} :
                     phase_w + {{(`PHASE_W-1){1'b0}}, 1'b1};
    end
  end
  assign osc_phase = osc_phase_r;

  // ============================================================
  // rc mode strap: three stages, accepted when the last two agree
  logic rc_s1_r;
  logic rc_s2_r;
  logic rc_s3_r;
  logic rc_mode_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      rc_s1_r <= 1'b0;
      rc_s2_r <= 1'b0;
      rc_s3_r <= 1'b0;
      rc_mode_r <= 1'b0;
    end else begin
      rc_s1_r <= resistor_capacitor_oscillator;
      rc_s2_r <= rc_s1_r;
      rc_s3_r <= rc_s2_r;
      if (rc_s2_r == rc_s3_r) begin
        rc_mode_r <= rc_s3_r;
      end
    end
  end

  // ============================================================
  // quarter-rate clock: high in the last two periods of each cycle
  logic qclk_r;
  logic qclk_nxt;
  always_comb begin
    qclk_nxt = qclk_r;
    if (!rc_mode_r) begin
      qclk_nxt = 1'b0;
    end else if (phase_w == `QCLK_RISE_PRE) begin
      qclk_nxt = 1'b1;
    end else if (phase_w == `QCLK_FALL_PRE) begin
      qclk_nxt = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      qclk_r <= 1'b0;
    end else begin
      qclk_r <= qclk_nxt;
    end
  end
  assign quarter_rate_clock_out = qclk_r;

  // ============================================================
  // field decode of the word arriving from program memory
  decode_fields_if dec_if ();
  assign dec_if.word = instr_word;
  field_decoder u_dec (
    .dec(dec_if.decoder)
  );

  // ============================================================
  // execution slot and fetch sequencing
  instr_decode_pkg::slot_t slot_r;
  instr_decode_pkg::slot_t slot_nxt;
  wire executing = (slot_r == instr_decode_pkg::ST_EXEC);
  // a redirect is only honoured from a real op, never from the no-op
  wire redirect = executing && (pc_load || skip_taken);
  wire jump = executing && pc_load;

  assign slot_nxt = redirect ? instr_decode_pkg::ST_FLUSH :
                    instr_decode_pkg::ST_EXEC;

  logic fetch_req_r;
  logic [PC_W-1:0] fetch_addr_r;
  logic [PC_W-1:0] fetch_addr_nxt;
  assign fetch_addr_nxt = jump ? pc_target :
                          fetch_addr_r + PC_W'(1'b1);

  // first fetch of address zero is issued straight out of reset
  always_ff @(posedge clk) begin
    if (srst) begin
      slot_r <= instr_decode_pkg::ST_FLUSH;
      fetch_req_r <= 1'b1;
      fetch_addr_r <= {PC_W{1'b0}};
    end else if (cyc_last) begin
      slot_r <= slot_nxt;
      fetch_req_r <= 1'b1;
      fetch_addr_r <= fetch_addr_nxt;
    end else begin
      fetch_req_r <= 1'b0;
    end
  end
  assign fetch_req = fetch_req_r;
  assign fetch_addr = fetch_addr_r;

  // ============================================================
  // operand registers, loaded from the word at the end of the cycle
  instr_decode_pkg::op_group_t group_r;
  logic [`REG_IDX_W-1:0] reg_index_r;
  logic target_r;
  logic [`FLAG_POS_W-1:0] flag_pos_r;
  logic [`LIT_W-1:0] literal_r;
  logic long_lit_r;
  logic exec_valid_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      group_r <= instr_decode_pkg::GRP_BYTE;
      reg_index_r <= {`REG_IDX_W{1'b0}};
      target_r <= 1'b0;
      flag_pos_r <= {`FLAG_POS_W{1'b0}};
      literal_r <= {`LIT_W{1'b0}};
      long_lit_r <= 1'b0;
      exec_valid_r <= 1'b0;
    end else if (cyc_last) begin
      group_r <= dec_if.group;
      reg_index_r <= dec_if.reg_index;
      target_r <= dec_if.result_target;
      flag_pos_r <= dec_if.flag_position;
      literal_r <= dec_if.literal_value;
      long_lit_r <= dec_if.long_literal;
      exec_valid_r <= !redirect;
    end
  end
  assign op_group = group_r;
  assign reg_index = reg_index_r;
  assign result_target = target_r;
  assign flag_position = flag_pos_r;
  assign literal_value = literal_r;
  assign long_literal = long_lit_r;
  assign exec_valid = exec_valid_r;

  // ============================================================
  // write strobes in the last period of an executing cycle
  wire is_byte = (group_r == instr_decode_pkg::GRP_BYTE);
  wire is_bit = (group_r == instr_decode_pkg::GRP_BIT);
  wire is_short_lit = (group_r == instr_decode_pkg::GRP_LITERAL) &&
                      !long_lit_r;
  wire wr_slot = pre_last && exec_valid_r;
  wire acc_wr_nxt = wr_slot && ((is_byte && !target_r) || is_short_lit);
  wire file_wr_nxt = wr_slot && ((is_byte && target_r) || is_bit);
  wire stat_wr_nxt = wr_slot && (is_byte || is_short_lit);

  logic acc_write_r;
  logic file_write_r;
  logic status_write_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      acc_write_r <= 1'b0;
      file_write_r <= 1'b0;
      status_write_r <= 1'b0;
    end else begin
      acc_write_r <= acc_wr_nxt;
      file_write_r <= file_wr_nxt;
      status_write_r <= stat_wr_nxt;
    end
  end
  assign acc_write = acc_write_r;
  assign file_write = file_write_r;
  assign status_write = status_write_r;

  // ============================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_gap3;
    !cyc_last [*3];
  endsequence

  sequence s_flush_cycle;
    !exec_valid_r [*4] ##1 exec_valid_r;
  endsequence

  sequence s_quiet4;
    (!acc_write_r && !file_write_r && !status_write_r) [*4];
  endsequence

  AST_FETCH_EVERY_CYCLE: assert property (
    fetch_req_r |=> !fetch_req_r [*3] ##1 fetch_req_r)
    else $error("fetch strobe not once per instruction cycle");

  AST_CYCLE_FOUR_PERIODS: assert property (
    cyc_last |=> s_gap3 ##1 cyc_last)
    else $error("instruction cycle not four periods");

  AST_GROUP_LEGAL: assert property (
    cyc_last |=> (group_r == instr_decode_pkg::GRP_LITERAL) ==
    $past(instr_word[`GRP_HI_POS]))
    else $error("illegal operation group");

  AST_BYTE_TARGET: assert property (
    cyc_last && !instr_word[`GRP_HI_POS] && !instr_word[`GRP_LO_POS] &&
    !redirect |=> ##3 (acc_write_r == !$past(instr_word[`TARGET_POS], 4))
    && (file_write_r == $past(instr_word[`TARGET_POS], 4)))
    else $error("byte op wrote wrong destination");

  AST_REG_INDEX: assert property (
    cyc_last && !instr_word[`GRP_HI_POS]
    |=> reg_index_r == $past(instr_word[`REG_IDX_HI:`REG_IDX_LO]))
    else $error("register index not taken from word");

  AST_FLAG_POS: assert property (
    cyc_last && !instr_word[`GRP_HI_POS] && instr_word[`GRP_LO_POS]
    |=> flag_pos_r == $past(instr_word[`FLAG_POS_HI:`FLAG_POS_LO]))
    else $error("flag position not taken from word");

  AST_SHORT_LITERAL: assert property (
    group_r == instr_decode_pkg::GRP_LITERAL && !long_lit_r
    |-> literal_r[`LIT_W-1:`LIT_SHORT_W] == '0)
    else $error("short literal carries upper bits");

  AST_DONT_CARE_BITS: assert property (
    cyc_last && instr_word[`GRP_HI_POS] && instr_word[`GRP_LO_POS]
    |=> literal_r == {3'h0, $past(instr_word[`LIT_SHORT_HI:`LIT_LO])})
    else $error("ignored bits leaked into literal");

  AST_REDIRECT_NOP: assert property (
    cyc_last && redirect |=> s_flush_cycle)
    else $error("redirect did not insert one no-op cycle");

  AST_NO_REDIRECT: assert property (
    cyc_last && !redirect |=> exec_valid_r [*4])
    else $error("cycle lost without redirect");

  AST_JUMP_TARGET: assert property (
    cyc_last && jump |=> fetch_req_r && fetch_addr_r == $past(pc_target))
    else $error("no-op cycle did not fetch target");

  AST_NOP_NO_WRITES: assert property (
    cyc_last && redirect |=> s_quiet4)
    else $error("write during no-op cycle");

  AST_QCLK_PERIOD: assert property (
    $rose(qclk_r) && rc_mode_r |-> ##2 !qclk_r ##2 (qclk_r || !rc_mode_r))
    else $error("quarter-rate clock period wrong");

  AST_QCLK_OFF: assert property (
    !rc_mode_r && !$past(rc_mode_r) |-> !qclk_r)
    else $error("quarter-rate clock runs outside rc mode");

  AST_CYCLE_TIME: assert property (
    fetch_req_r |-> osc_phase_r == {`PHASE_W{1'b0}})
    else $error("fetch strobe outside first period");
endmodule

`default_nettype wire

// *** instr_decode_pkg_note_placeholder_do_not_use.sv ***
// intentionally empty compilation unit
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// *** prog_mem_model.sv ***
// program memory model answering the core's instruction fetches
`timescale 1ns/100ps
`default_nettype none
`include "instr_decode_params.svh"

module prog_mem_model #(
  parameter int AW = 11
) (
  input wire logic clk, // oscillator clock
  input wire logic fetch_req, // fetch strobe from the core
  input wire logic [AW-1:0] fetch_addr, // address to read
  input wire logic slow, // answer only in the last period
  output logic [`WORD_W-1:0] instr_word // word, junk until answered
);
  // ============================================================
  // storage, filled by the bench before reset is released
  logic [`WORD_W-1:0] mem [0:(1<<AW)-1];
  logic [AW-1:0] addr_r = '0;
  logic [1:0] ph_r = 2'h0;
  logic [`WORD_W-1:0] junk_r = 14'h1555;
  wire logic answered;

  // ============================================================
  // answer timing
  // fast answers from period 1, slow ones only in the sampled period
  assign answered = ph_r >= (slow ? 2'h3 : 2'h1);
  // before the answer the line churns every period, never the old word
  assign instr_word = answered ? mem[addr_r] : ~mem[addr_r] ^ junk_r;

  always_ff @(posedge clk) begin
    junk_r <= {junk_r[12:0], ~junk_r[13]};
    if (fetch_req) begin
      addr_r <= fetch_addr;
      ph_r <= 2'h1;
    end else begin
      ph_r <= ph_r + 2'h1;
    end
  end
endmodule

`default_nettype wire

// *** tb.sv ***
// self-checking bench for the instruction decode and cycle timing block
`timescale 1ns/100ps
`default_nettype none
`include "instr_decode_params.svh"

module tb;
  localparam int addr_w = 11;
  localparam int n_cycles = 600;
  localparam int rc_off = 4 * (n_cycles / 2);

  typedef struct {
    logic exec;
    logic [addr_w-1:0] addr;
    logic [`WORD_W-1:0] word;
  } note_t;

  logic clk = 1'h0;
  logic srst = 1'h1;
  logic rc_mode = 1'h1;
  logic pc_load = 1'h0;
  logic [addr_w-1:0] pc_target = '0;
  logic skip_taken = 1'h0;
  logic slow = 1'h0;
  logic [`WORD_W-1:0] instr_word;
  logic fetch_req, exec_valid, acc_write, file_write, status_write;
  logic [addr_w-1:0] fetch_addr;
  instr_decode_pkg::op_group_t op_group;
  logic [`REG_IDX_W-1:0] reg_index;
  logic result_target, long_literal, quarter_rate_clock_out;
  logic [`FLAG_POS_W-1:0] flag_position;
  logic [`LIT_W-1:0] literal_value;
  logic [`PHASE_W-1:0] osc_phase;
  logic [`WORD_W-1:0] img [0:(1<<addr_w)-1];
  note_t notes[$];
  logic [31:0] seed = 32'h3229;
  int miscompares = 0;
  int tests_run = 0;

  always #5 clk = ~clk;

  instruction_field_decode_timing #(
    .PC_W(addr_w)
  ) u_instruction_field_decode_timing (
    .clk(clk), .srst(srst), .resistor_capacitor_oscillator(rc_mode),
    .instr_word(instr_word), .pc_load(pc_load), .pc_target(pc_target),
    .skip_taken(skip_taken), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .op_group(op_group), .reg_index(reg_index),
    .result_target(result_target), .flag_position(flag_position),
    .literal_value(literal_value), .long_literal(long_literal),
    .exec_valid(exec_valid), .acc_write(acc_write),
    .file_write(file_write), .status_write(status_write),
    .osc_phase(osc_phase), .quarter_rate_clock_out(quarter_rate_clock_out)
  );

  prog_mem_model #(.AW(addr_w)) u_prog_mem_model (
    .clk(clk), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .slow(slow), .instr_word(instr_word)
  );

  // ============================================================
  // helpers
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // strobe expectation is {acc, file, status}
  task automatic check_fields(input logic [`WORD_W-1:0] w,
                              output logic [2:0] stb);
    if (w[13]) begin
      check("op_group", op_group, instr_decode_pkg::GRP_LITERAL);
      check("long_literal", long_literal, !w[12]);
      if (w[12]) begin
        // bits 11:8 are random in the image, so don't-cares are exercised
        check("short_lit", literal_value, {3'h0, w[7:0]});
        stb = 3'h5;
      end else begin
        check("long_lit", literal_value, w[10:0]);
        stb = 3'h0;
      end
    end else if (w[12]) begin
      check("op_group", op_group, instr_decode_pkg::GRP_BIT);
      check("flag_position", flag_position, w[9:7]);
      check("reg_index", reg_index, w[6:0]);
      stb = 3'h2;
    end else begin
      check("op_group", op_group, instr_decode_pkg::GRP_BYTE);
      check("reg_index", reg_index, w[6:0]);
      check("result_target", result_target, w[7]);
      stb = w[7] ? 3'h3 : 3'h5;
    end
  endtask

  // ============================================================
  // driver: random program, random redirects, notes per cycle
  initial begin : driver
    logic e;
    logic ld;
    logic sk;
    logic [addr_w-1:0] fa;
    logic [addr_w-1:0] prev;
    logic [addr_w-1:0] tgt;
    note_t n;
    for (int i = 0; i < (1 << addr_w); i++) begin
      seed = next_rand(seed);
      img[i] = seed[13:0];
      u_prog_mem_model.mem[i] = seed[13:0];
    end
    e = 1'h0;
    fa = '0;
    prev = '0;
    repeat (20) @(posedge clk);
    srst <= 1'h0;
    for (int c = 0; c < n_cycles; c++) begin
      seed = next_rand(seed);
      ld = seed[2:0] == 3'h0;
      sk = seed[2:0] == 3'h1;
      tgt = seed[13:3];
      // redirects also land in no-op cycles, where they must be ignored
      pc_load <= ld;
      skip_taken <= sk;
      pc_target <= tgt;
      slow <= seed[20];
      if (c == n_cycles / 2) begin
        rc_mode <= 1'h0;
      end
      n.exec = e;
      n.addr = fa;
      n.word = img[prev];
      notes.push_back(n);
      prev = fa;
      if (e && (ld || sk)) begin
        fa = ld ? tgt : fa + 1'h1;
        e = 1'h0;
      end else begin
        fa = fa + 1'h1;
        e = 1'h1;
      end
      repeat (4) @(posedge clk);
    end
    check("notes_left", notes.size(), 0);
    print_verdict();
  end

  // ============================================================
  // monitor: sampled mid-period, one note per instruction cycle
  initial begin : monitor
    note_t n;
    logic [2:0] stb;
    logic q_exp;
    int k;
    k = 0;
    for (int i = 0; i < 40 && srst; i++) @(negedge clk);
    if (srst) begin
      miscompares++;
      print_verdict();
    end else begin
      forever begin
        stb = 3'h0;
        check("osc_phase", osc_phase, k % 4);
        check("fetch_req", fetch_req, k % 4 == 0);
        // the strap passes a synchroniser, so skip its settling window
        // the strap is still settling in the first cycle, so it stays low
        q_exp = k >= 4 && k < rc_off && k % 4 >= 2;
        if (k < rc_off || k >= rc_off + 8) begin
          check("qclk", quarter_rate_clock_out, q_exp);
        end
        if (k % 4 == 3) begin
          if (notes.size() == 0) begin
            check("note", 32'h0, 32'h1);
          end else begin
            n = notes.pop_front();
            check("exec_valid", exec_valid, n.exec);
            check("fetch_addr", fetch_addr, n.addr);
            if (n.exec) begin
              check_fields(n.word, stb);
            end
          end
        end
        check("strobes", {acc_write, file_write, status_write}, stb);
        k++;
        @(negedge clk);
      end
    end
  end
endmodule

`default_nettype wire
